// ---- qpp_pkg.sv ----
// qpp_pkg: constants and carrier types for the parallel port block.
// assumes a single 50 MHz core clock and an 8-bit cpu internal bus.
package qpp_pkg;

    // ==========================================================
    // widths and reset values
    localparam int         QPP_WIDTH      = 8;
    localparam logic [7:0] QPP_ZERO_RESET = 8'hFF;
    localparam logic [7:0] QPP_ONE_RESET  = 8'hFF;
    localparam logic [7:0] QPP_TWO_RESET  = 8'hFF;
    localparam logic [7:0] QPP_ALL_ONES   = 8'hFF;
    localparam logic [7:0] QPP_ZERO       = 8'h00;

    // ==========================================================
    // port select codes and bit positions of port one alternates
    localparam logic [1:0] QPP_SEL_ZERO   = 2'h0;
    localparam logic [1:0] QPP_SEL_ONE    = 2'h1;
    localparam logic [1:0] QPP_SEL_TWO    = 2'h2;
    localparam int         QPP_CNT_BIT    = 0;
    localparam int         QPP_TRIG_BIT   = 1;
    localparam int         QPP_SS_BIT     = 5;

    // cpu access operation
    typedef enum logic [2:0] {
        QPP_OP_NONE  = 3'h0,
        QPP_OP_WRITE = 3'h1,  // write byte to latch
        QPP_OP_RDLAT = 3'h2,  // read latch (read-modify-write source)
        QPP_OP_RDPIN = 3'h3,  // read pin
        QPP_OP_BIT   = 3'h4   // single bit move, clear or set
    } qpp_op_t;

    // cpu request carrier
    typedef struct packed {
        qpp_op_t    op;
        logic [1:0] port;
        logic [2:0] bit_idx;
        logic       bit_val;
        logic [7:0] wdata;
    } qpp_req_t;

    // external memory carrier
    typedef struct packed {
        logic       active;     // access in progress
        logic       zero_oe;    // drive low address / data on port zero
        logic [7:0] zero_out;
        logic       two_en;     // port two carries an address byte
        logic [7:0] two_out;
    } qpp_ext_t;

    // pin output carrier for one port
    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe;
    } qpp_pins_t;

    // block state
    typedef struct packed {
        logic [7:0] port_zero_latch;
        logic [7:0] port_one_latch;
        logic [7:0] port_two_latch;
        logic [7:0] zero_s1;
        logic [7:0] zero_s2;
        logic [7:0] one_s1;
        logic [7:0] one_s2;
        logic [7:0] two_s1;
        logic [7:0] two_s2;
        logic [7:0] rdata;
        logic       rvalid;
        qpp_pins_t  zero;
        qpp_pins_t  two;
        logic [7:0] two_pullup;
        logic [7:0] one_analog;
        logic       count_in;
        logic       trig_in;
        logic       ss_n_in;
        logic       three_out;
        logic       three_oe;
        logic       three_pullup;
    } qpp_state_t;

endpackage

// ---- qpp_ports.sv ----
// qpp_ports: latch, pin read and output control for ports zero to two,
// and the spi data-out pin that shares port three bit three.
// assumes requests and pins synchronous to i_clock; pad logic resolves
// output enables and pull-ups into real pin levels outside this block.
`timescale 1ns/1ps

module qpp_ports
    import qpp_pkg::*;
(
    input  wire logic       i_clock,
    input  wire logic       i_resetn,
    input  wire qpp_req_t   i_req,
    input  wire qpp_ext_t   i_ext,
    input  wire logic [7:0] i_port_zero_pin,
    input  wire logic [7:0] i_port_one_pin,
    input  wire logic [7:0] i_port_two_pin,
    input  wire logic [7:0] i_two_periph_en,
    input  wire logic [7:0] i_two_periph_out,
    input  wire logic       i_spi_miso_en,
    input  wire logic       i_spi_miso_out,
    output logic [7:0]      o_rdata,
    output logic            o_rvalid,
    output qpp_pins_t       o_port_zero,
    output qpp_pins_t       o_port_two,
    output logic [7:0]      o_two_pullup,
    output logic [7:0]      o_one_analog,
    output logic            o_timer_two_count_input,
    output logic            o_timer_two_capture_trigger,
    output logic            o_spi_select_n,
    output logic            o_port_three_bit_three_out,
    output logic            o_port_three_bit_three_oe,
    output logic            o_port_three_bit_three_pullup
);

    // ==========================================================
    // helpers
    // byte of a selected port, latch or synchronised pin, used by two paths
    function automatic logic [7:0] pick(input logic [1:0] sel, input logic [7:0] a,
                                        input logic [7:0] b, input logic [7:0] c);
        case (sel)
            QPP_SEL_ZERO: pick = a;
            QPP_SEL_ONE:  pick = b;
            QPP_SEL_TWO:  pick = c;
            default:      pick = QPP_ZERO;
        endcase
    endfunction

    qpp_state_t s_q;
    qpp_state_t s_d;
    logic [7:0] cur_latch;
    logic [7:0] new_byte;
    logic       wr_any;

    // ==========================================================
    // next-state logic
    always_comb begin
        s_d       = s_q;
        cur_latch = pick(i_req.port, s_q.port_zero_latch, s_q.port_one_latch,
                         s_q.port_two_latch);
        new_byte  = i_req.wdata;
        wr_any    = 1'b0;
        // synchroniser chains: stage one feeds only stage two, so a pin
        // that moves near the edge never reaches the bus half settled
        s_d.zero_s1 = i_port_zero_pin;
        s_d.zero_s2 = s_q.zero_s1;
        s_d.one_s1  = i_port_one_pin;
        s_d.one_s2  = s_q.one_s1;
        s_d.two_s1  = i_port_two_pin;
        s_d.two_s2  = s_q.two_s1;
        s_d.rvalid  = 1'b0;

        case (i_req.op)
            QPP_OP_WRITE: begin
                wr_any = 1'b1;
            end
            QPP_OP_BIT: begin
                // whole byte read from latch, one bit changed, byte written back
                new_byte              = cur_latch;
                new_byte[i_req.bit_idx] = i_req.bit_val;
                wr_any                = 1'b1;
            end
            QPP_OP_RDLAT: begin
                s_d.rdata  = cur_latch;
                s_d.rvalid = 1'b1;
            end
            QPP_OP_RDPIN: begin
                // plain reads see the synchronised pin, never the latch
                s_d.rdata  = pick(i_req.port, s_q.zero_s2, s_q.one_s2, s_q.two_s2);
                s_d.rvalid = 1'b1;
            end
            default: begin
                wr_any = 1'b0;
            end
        endcase

        if (wr_any) begin
            case (i_req.port)
                QPP_SEL_ZERO: s_d.port_zero_latch = new_byte;
                QPP_SEL_ONE:  s_d.port_one_latch  = new_byte;
                QPP_SEL_TWO:  s_d.port_two_latch  = new_byte;
                default:      s_d.port_two_latch  = s_q.port_two_latch;
            endcase
        end
        // external access forces ones and wins over a cpu write
        if (i_ext.active) begin
            s_d.port_zero_latch = QPP_ALL_ONES;
        end

        // port zero driver: push-pull bus in memory mode, else open drain
        if (i_ext.active) begin
            s_d.zero.out = i_ext.zero_out;
            s_d.zero.oe  = i_ext.zero_oe ? QPP_ALL_ONES : QPP_ZERO;
        end else begin
            s_d.zero.out = QPP_ZERO;
            s_d.zero.oe  = ~s_d.port_zero_latch;
        end

        // port two: address bytes, peripheral or latch with pull-up
        for (int i = 0; i < QPP_WIDTH; i++) begin
            if (i_ext.two_en) begin
                s_d.two.out[i]     = i_ext.two_out[i];
                s_d.two.oe[i]      = 1'b1;
                s_d.two_pullup[i]  = 1'b0;
            end else if (i_two_periph_en[i]) begin
                s_d.two.out[i]     = i_two_periph_out[i];
                s_d.two.oe[i]      = 1'b1;
                s_d.two_pullup[i]  = 1'b0;
            end else begin
                s_d.two.out[i]     = 1'b0;
                s_d.two.oe[i]      = ~s_d.port_two_latch[i];
                s_d.two_pullup[i]  = s_d.port_two_latch[i];
            end
        end

        // spi data out on port three bit three: the same pull-up pin style
        // as the other port three pins; with the spi off the pin idles
        // released with its pull-up on, since no latch path lives here
        if (i_spi_miso_en) begin
            s_d.three_out    = i_spi_miso_out;
            s_d.three_oe     = 1'b1;
            s_d.three_pullup = 1'b0;
        end else begin
            s_d.three_out    = 1'b0;
            s_d.three_oe     = 1'b0;
            s_d.three_pullup = 1'b1;
        end

        // port one: no drivers at all, latch chooses analog or digital
        s_d.one_analog = s_d.port_one_latch;
        // digital alternates only when the bit is set to digital input;
        // an analog pin would otherwise feed mid-rail noise to the timer
        s_d.count_in = ~s_d.port_one_latch[QPP_CNT_BIT] & s_q.one_s2[QPP_CNT_BIT];
        s_d.trig_in  = ~s_d.port_one_latch[QPP_TRIG_BIT] & s_q.one_s2[QPP_TRIG_BIT];
        s_d.ss_n_in  = s_d.port_one_latch[QPP_SS_BIT] | s_q.one_s2[QPP_SS_BIT];
    end

    // ==========================================================
    // state register; pins idle released until the first edge
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            s_q                 <= '0;
            s_q.port_zero_latch <= QPP_ZERO_RESET;
            s_q.port_one_latch  <= QPP_ONE_RESET;
            s_q.port_two_latch  <= QPP_TWO_RESET;
            s_q.two_pullup      <= QPP_ALL_ONES;
            s_q.one_analog      <= QPP_ALL_ONES;
            s_q.ss_n_in         <= 1'b1;
            s_q.three_pullup    <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // outputs straight from the state flops
    assign o_rdata                       = s_q.rdata;
    assign o_rvalid                      = s_q.rvalid;
    assign o_port_zero                   = s_q.zero;
    assign o_port_two                    = s_q.two;
    assign o_two_pullup                  = s_q.two_pullup;
    assign o_one_analog                  = s_q.one_analog;
    assign o_timer_two_count_input       = s_q.count_in;
    assign o_timer_two_capture_trigger   = s_q.trig_in;
    assign o_spi_select_n                = s_q.ss_n_in;
    assign o_port_three_bit_three_out    = s_q.three_out;
    assign o_port_three_bit_three_oe     = s_q.three_oe;
    assign o_port_three_bit_three_pullup = s_q.three_pullup;

    // ==========================================================
    // sequences for the multi-step behaviours
    // a pin read of port zero, answered one cycle later
    sequence s_pin_read_zero;
        i_req.op == QPP_OP_RDPIN && i_req.port == QPP_SEL_ZERO;
    endsequence

    // an external access that drives the low address/data byte
    sequence s_zero_bus_drive;
        i_ext.active && i_ext.zero_oe;
    endsequence

    // ==========================================================
    // checks on port zero
    a_ext_forces_ones: assert property (@(posedge i_clock) disable iff (!i_resetn)
        i_ext.active |=> s_q.port_zero_latch == QPP_ALL_ONES)
        else $error("port zero latch not ones");
    a_ext_push_pull: assert property (@(posedge i_clock) disable iff (!i_resetn)
        s_zero_bus_drive |=> (o_port_zero.oe == QPP_ALL_ONES
                              && o_port_zero.out == $past(i_ext.zero_out)))
        else $error("port zero not driven from bus");
    a_zero_open_drain: assert property (@(posedge i_clock) disable iff (!i_resetn)
        !$past(i_ext.active) |-> (o_port_zero.oe == ~s_q.port_zero_latch
                                  && o_port_zero.out == QPP_ZERO))
        else $error("port zero open drain broken");
    a_zero_drive_low: assert property (@(posedge i_clock) disable iff (!i_resetn)
        !$past(i_ext.active) |-> (o_port_zero.out & o_port_zero.oe) == QPP_ZERO)
        else $error("port zero drives high");
    a_pin_sync: assert property (@(posedge i_clock) disable iff (!i_resetn)
        s_pin_read_zero ##1 1 |-> o_rdata == $past(i_port_zero_pin, 3))
        else $error("pin read not synchronised");

    // ==========================================================
    // checks on the cpu access path
    a_write_latch: assert property (@(posedge i_clock) disable iff (!i_resetn)
        (i_req.op == QPP_OP_WRITE && i_req.port == QPP_SEL_TWO)
        |=> s_q.port_two_latch == $past(i_req.wdata))
        else $error("port two write lost");
    a_rdlat_value: assert property (@(posedge i_clock) disable iff (!i_resetn)
        (i_req.op == QPP_OP_RDLAT && i_req.port == QPP_SEL_ONE)
        |=> (o_rvalid && o_rdata == $past(s_q.port_one_latch)))
        else $error("latch read wrong");
    a_rvalid_cause: assert property (@(posedge i_clock) disable iff (!i_resetn)
        o_rvalid |-> ($past(i_req.op) == QPP_OP_RDLAT || $past(i_req.op) == QPP_OP_RDPIN))
        else $error("read valid without a read");
    a_bit_op: assert property (@(posedge i_clock) disable iff (!i_resetn)
        (i_req.op == QPP_OP_BIT && i_req.port == QPP_SEL_ONE && i_req.bit_idx == 3'h2)
        |=> s_q.port_one_latch == {$past(s_q.port_one_latch[7:3]), $past(i_req.bit_val),
                                   $past(s_q.port_one_latch[1:0])})
        else $error("bit op changed other bits");

    // ==========================================================
    // checks on port one
    a_one_analog: assert property (@(posedge i_clock) disable iff (!i_resetn)
        o_one_analog == s_q.port_one_latch)
        else $error("analog select not from latch");
    a_count_gate: assert property (@(posedge i_clock) disable iff (!i_resetn)
        s_q.port_one_latch[QPP_CNT_BIT] |-> !o_timer_two_count_input)
        else $error("count input leaks from analog pin");
    a_select_gate: assert property (@(posedge i_clock) disable iff (!i_resetn)
        s_q.port_one_latch[QPP_SS_BIT] |-> o_spi_select_n)
        else $error("select leaks from analog pin");

    // ==========================================================
    // checks on port two and the shared spi pin
    a_two_keep: assert property (@(posedge i_clock) disable iff (!i_resetn)
        (i_ext.two_en && i_req.op == QPP_OP_NONE)
        |=> s_q.port_two_latch == $past(s_q.port_two_latch))
        else $error("port two latch changed by address");
    a_two_addr: assert property (@(posedge i_clock) disable iff (!i_resetn)
        i_ext.two_en |=> (o_port_two.oe == QPP_ALL_ONES
                          && o_port_two.out == $past(i_ext.two_out)))
        else $error("port two address not driven");
    a_two_pullup: assert property (@(posedge i_clock) disable iff (!i_resetn)
        (!i_ext.two_en && i_two_periph_en == QPP_ZERO) |=> o_two_pullup == s_q.port_two_latch)
        else $error("port two pull-up wrong");
    a_two_periph: assert property (@(posedge i_clock) disable iff (!i_resetn)
        (!i_ext.two_en && i_two_periph_en != QPP_ZERO)
        |=> (o_port_two.oe & $past(i_two_periph_en)) == $past(i_two_periph_en))
        else $error("peripheral pin not taken over");
    a_miso_share: assert property (@(posedge i_clock) disable iff (!i_resetn)
        i_spi_miso_en |=> (o_port_three_bit_three_oe
                           && o_port_three_bit_three_out == $past(i_spi_miso_out)))
        else $error("spi data out not on shared pin");
    a_miso_idle: assert property (@(posedge i_clock) disable iff (!i_resetn)
        !i_spi_miso_en |=> (!o_port_three_bit_three_oe && o_port_three_bit_three_pullup))
        else $error("shared pin not released");

endmodule

// ---- qpp_pad.sv ----
// qpp_pad: pin-side model of the external devices on ports zero and two.
// assumes external pull-up resistors on port zero, whose own drivers are open drain outside memory mode.
`timescale 1ns/1ps
module qpp_pad
    import qpp_pkg::*;
(
    input  wire logic       i_clock,
    input  wire qpp_pins_t  i_zero,
    input  wire qpp_pins_t  i_two,
    input  wire logic [7:0] i_two_pullup,
    input  wire logic [7:0] i_drv_en,
    input  wire logic [7:0] i_drv_val,
    output logic [7:0]      o_zero_pin,
    output logic [7:0]      o_two_pin
);
    logic [7:0] two_last_q;

    // ==========================================================
    // wire resolution: chip drive, then device drive, then pull-up
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            o_zero_pin[i] = i_zero.oe[i] ? i_zero.out[i] : (i_drv_en[i] ? i_drv_val[i] : 1'b1);
            o_two_pin[i]  = i_two.oe[i] ? i_two.out[i] : i_drv_en[i] ? i_drv_val[i] :
                            i_two_pullup[i] ? 1'b1 : ~two_last_q[i];
        end
    end

    // a line nobody holds shows no stable value, so it toggles each cycle
    always_ff @(posedge i_clock) two_last_q <= o_two_pin;
endmodule

// ---- testbench.sv ----
// testbench: self-checking bench for the parallel port block.
// assumes qpp_pkg and qpp_pad are compiled first.
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_mismatch++; \
    $display("Error t=%0t got %h exp %h", $time, a, b); end end
module testbench;
    import qpp_pkg::*;
    logic       i_clock = 1'b0;
    logic       i_resetn = 1'b0;
    qpp_req_t   req;
    qpp_ext_t   ext;
    qpp_pins_t  o_zero, o_two;
    logic [7:0] zero_pin, one_pin, two_pin, pen, pout, de, dv, o_rdata, o_pullup, o_analog;
    logic       o_rvalid, o_cnt, o_trig, o_ss_n, me, mo, o_mo, o_moe, o_mpu;
    logic [7:0] lat [3];
    int         n_mismatch, checked, cycles, p;

    qpp_ports dut (.i_clock(i_clock), .i_resetn(i_resetn), .i_req(req), .i_ext(ext),
        .i_port_zero_pin(zero_pin), .i_port_one_pin(one_pin), .i_port_two_pin(two_pin),
        .i_two_periph_en(pen), .i_two_periph_out(pout), .i_spi_miso_en(me),
        .i_spi_miso_out(mo), .o_rdata(o_rdata), .o_rvalid(o_rvalid), .o_port_zero(o_zero),
        .o_port_two(o_two), .o_two_pullup(o_pullup), .o_one_analog(o_analog),
        .o_timer_two_count_input(o_cnt), .o_timer_two_capture_trigger(o_trig),
        .o_spi_select_n(o_ss_n), .o_port_three_bit_three_out(o_mo),
        .o_port_three_bit_three_oe(o_moe), .o_port_three_bit_three_pullup(o_mpu));
    qpp_pad pad (.i_clock(i_clock), .i_zero(o_zero), .i_two(o_two), .i_two_pullup(o_pullup),
        .i_drv_en(de), .i_drv_val(dv), .o_zero_pin(zero_pin), .o_two_pin(two_pin));

    always #10 i_clock = ~i_clock;

    // ==========================================================
    // run control; ceiling well above the under two hundred cycles needed
    always @(posedge i_clock) begin
        cycles++;
        if (cycles == 3000) begin
            n_mismatch++;
            conclude();
        end
    end

    task automatic conclude();
        $display("checked %0d n_mismatch %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    task automatic cyc(int n);
        repeat (n) @(negedge i_clock);
    endtask

    // request is held until the next call, so no signal is assigned twice per step
    task automatic issue(qpp_op_t op, int q, int b, int v, logic [7:0] d);
        req = '{op, q[1:0], b[2:0], v[0], d};
        if (op == QPP_OP_WRITE) lat[q] = d;
        if (op == QPP_OP_BIT) lat[q][b] = v[0];
        if (ext.active) lat[0] = 8'hFF;
        cyc(1);
    endtask

    task automatic rd(qpp_op_t op, int q, logic [7:0] e);
        issue(op, q, 0, 0, 8'h00);
        `CHK(o_rvalid, 1'b1)
        `CHK(o_rdata, e)
    endtask

    // expected pin level: latch zero drives low, else device drive or pull-up
    function automatic logic [7:0] pexp(logic [7:0] l);
        return l & ((dv & de) | ~de);
    endfunction

    initial begin
        p = $urandom(32'h6688);
        req = '0; ext = '0; one_pin = 8'h00; pen = 8'h00; pout = 8'h00; de = 8'h00; dv = 8'h00;
        me = 1'b0; mo = 1'b0;
        lat = '{8'hFF, 8'hFF, 8'hFF};
        cyc(4);
        i_resetn = 1'b1;
        `CHK(o_analog, QPP_ONE_RESET)
        `CHK(o_zero.oe, 8'h00)
        `CHK(o_moe, 1'b0)
        `CHK(o_mpu, 1'b1)
        for (int i = 0; i < 3; i++) rd(QPP_OP_RDLAT, i, 8'hFF);
        rd(QPP_OP_RDLAT, 3, 8'h00);
        $display("test reset done");
        // back-to-back writes, bit operations and latch reads
        repeat (40) begin
            p = $urandom % 3;
            if ($urandom % 2) issue(QPP_OP_WRITE, p, 0, 0, 8'($urandom));
            else issue(QPP_OP_BIT, p, $urandom % 8, $urandom % 2, 8'h00);
            rd(QPP_OP_RDLAT, p, lat[p]);
            `CHK(o_zero.oe, ~lat[0])
            `CHK(o_zero.out & o_zero.oe, 8'h00)
            `CHK(o_pullup, lat[2])
            `CHK(o_two.oe & ~o_two.out, ~lat[2])
            `CHK(o_analog, lat[1])
        end
        $display("test latch done");
        // pin reads with the external side driving random levels
        repeat (12) begin
            de = $urandom; dv = $urandom; one_pin = $urandom; p = $urandom % 3;
            if (p == 1) issue(QPP_OP_WRITE, 1, 0, 0, 8'($urandom));
            cyc(4);
            rd(QPP_OP_RDPIN, p, p == 1 ? one_pin : pexp(lat[p]));
            `CHK(o_cnt, ~lat[1][0] & one_pin[0])
            `CHK(o_trig, ~lat[1][1] & one_pin[1])
            `CHK(o_ss_n, lat[1][5] | one_pin[5])
        end
        $display("test pins done");
        // external access: write to port zero is lost, port two latch kept
        ext = '{1'b1, 1'b1, 8'($urandom), 1'b1, 8'($urandom)};
        lat[0] = 8'hFF;
        cyc(2);
        `CHK(o_zero.oe, 8'hFF)
        `CHK(o_zero.out, ext.zero_out)
        `CHK(o_two.out, ext.two_out)
        `CHK(o_two.oe, 8'hFF)
        issue(QPP_OP_WRITE, 0, 0, 0, 8'h5A);
        rd(QPP_OP_RDLAT, 0, 8'hFF);
        ext.zero_oe = 1'b0;
        cyc(2);
        `CHK(o_zero.oe, 8'h00)
        ext = '0;
        rd(QPP_OP_RDLAT, 2, lat[2]);
        $display("test external done");
        // peripheral ownership of port two pins and of the shared spi pin
        issue(QPP_OP_WRITE, 2, 0, 0, 8'($urandom));
        pen = $urandom; pout = $urandom; me = 1'b1; mo = 1'($urandom);
        cyc(2);
        `CHK(o_two.oe & pen, pen)
        `CHK(o_two.out & pen, pout & pen)
        `CHK(o_moe, 1'b1)
        `CHK(o_mo, mo)
        $display("test peripheral done");
        // mid-run reset: every latch returns to ones, pins released
        req = '0; pen = 8'h00; me = 1'b0;
        cyc(1);
        i_resetn = 1'b0;
        cyc(1);
        i_resetn = 1'b1;
        lat = '{8'hFF, 8'hFF, 8'hFF};
        `CHK(o_analog, QPP_ONE_RESET)
        `CHK(o_pullup, QPP_TWO_RESET)
        for (int i = 0; i < 3; i++) rd(QPP_OP_RDLAT, i, lat[i]);
        $display("test second reset done");
        conclude();
    end
endmodule
